// ### rtl/cmpdc_pkg.sv
// Package for the comparator digital control block: offsets, fields, reset values, types
package cmpdc_pkg;
    localparam logic [7:0] MODE_ADDR       = 8'h9D;
    localparam logic [7:0] MUX_A_ADDR      = 8'hA0;
    localparam logic [7:0] MUX_B_ADDR      = 8'hA1;
    localparam logic [7:0] MODE_B_ADDR     = 8'hA2;
    localparam logic [7:0] FLAG_ADDR       = 8'hA3;
    localparam logic [7:0] MODE_RESET      = 8'h02;
    localparam logic [7:0] MUX_RESET       = 8'h00;
    localparam int         LATCH_BIT       = 7;
    localparam int         RISE_IE_BIT     = 5;
    localparam int         FALL_IE_BIT     = 4;
    localparam logic [7:0] MODE_WR_MASK    = 8'h33;
    localparam int         FLAG_RISE_BIT   = 0;
    localparam int         FLAG_FALL_BIT   = 1;

    typedef struct packed {
        logic       rise_irq_enable;
        logic       fall_irq_enable;
        logic [1:0] speed_power_select;
    } cmpdc_cfg_s;

    typedef struct packed {
        logic sync_out;
        logic async_out;
        logic rise_flag;
        logic fall_flag;
        logic latched_compare_level;
        logic irq;
    } cmpdc_stat_s;
endpackage

// ### rtl/cmpdc_channel.sv
// One comparator channel: synchroniser, edge flags, overflow latch, interrupt request
module cmpdc_channel (
    input  wire logic                 sys_clk_in,    // System clock
    input  wire logic                 nrst_in,       // Async reset, active low
    input  wire logic                 raw_cmp_in,    // Raw analog comparator output
    input  wire logic                 overflow_in,   // Capture timer array overflow pulse
    input  wire logic                 clr_rise_in,   // Software clear of rising flag
    input  wire logic                 clr_fall_in,   // Software clear of falling flag
    input  wire cmpdc_pkg::cmpdc_cfg_s cfg_in,       // Enables and mode
    output cmpdc_pkg::cmpdc_stat_s    stat_out       // Status, all from flip-flops
);
    logic sync1_ff, sync2_ff, prev_ff;
    logic rise_ff, fall_ff, latch_ff, irq_ff, async_ff;
    logic rise_ev, fall_ev;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end else begin
            sync1_ff <= raw_cmp_in;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // Unsynchronised copy registered once so the output comes from a flip-flop
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) async_ff <= 1'b0;
        else          async_ff <= raw_cmp_in;
    end

    assign rise_ev = sync2_ff & ~prev_ff;
    assign fall_ev = ~sync2_ff & prev_ff;

    // Set wins over a simultaneous clear
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rise_ff <= 1'b0;
            fall_ff <= 1'b0;
        end else begin
            rise_ff <= rise_ev | (rise_ff & ~clr_rise_in);
            fall_ff <= fall_ev | (fall_ff & ~clr_fall_in);
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in)         latch_ff <= 1'b0;
        else if (overflow_in) latch_ff <= sync2_ff;
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) irq_ff <= 1'b0;
        else          irq_ff <= (rise_ff & cfg_in.rise_irq_enable)
                              | (fall_ff & cfg_in.fall_irq_enable);
    end

    assign stat_out = '{sync_out: sync2_ff, async_out: async_ff, rise_flag: rise_ff,
                        fall_flag: fall_ff, latched_compare_level: latch_ff, irq: irq_ff};

    rise_flag_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        rise_ev |=> rise_ff) else $error("rising edge did not set flag");
    latch_cap_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        overflow_in |=> latch_ff == $past(sync2_ff)) else $error("latched level wrong");
    latch_hold_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        !overflow_in |=> $stable(latch_ff)) else $error("latched level changed without overflow");
    rise_irq_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (rise_ff && cfg_in.rise_irq_enable) |=> irq_ff) else $error("rise irq missing");
    fall_irq_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (fall_ff && cfg_in.fall_irq_enable) |=> irq_ff) else $error("fall irq missing");
    irq_gate_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        (!cfg_in.rise_irq_enable && !cfg_in.fall_irq_enable) |=> !irq_ff)
        else $error("irq raised while disabled");
    sync_delay_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        $rose(raw_cmp_in) ##1 raw_cmp_in |=> sync2_ff) else $error("sync path not two stages");
endmodule

// ### rtl/cmpdc_top.sv
// Comparator digital control top: special-function registers and two channels
// Contract
// - On each capture timer overflow, bit 7 stores the synchronised comparator level.
// - Rising edges request interrupt only while rise enable bit 5 is one.
// - Falling edges request interrupt only while fall enable bit 4 is one.
// - Bits 1:0 pick speed/power mode, 00 fastest, 11 lowest power.
// - Reserved bits 6 and 3:2 read zero; software writes them back unchanged.
// - Each comparator has a mux register with plus and minus input fields.
// - Both comparators behave identically, differing only in connections.
// - Either output may interrupt; first also drives reset and PWM kill.
// - Synchronised and unsynchronised outputs go to the crossbar when selected.
module cmpdc_top (
    input  wire logic       sys_clk_in,            // System clock, 20 MHz
    input  wire logic       nrst_in,               // Async reset, active low
    input  wire logic [7:0] sfr_addr_in,           // Register address
    input  wire logic [7:0] sfr_wdata_in,          // Write data
    input  wire logic       sfr_wr_in,             // Write strobe
    input  wire logic       sfr_rd_in,             // Read strobe
    output logic      [7:0] sfr_rdata_out,         // Registered read data
    input  wire logic [1:0] raw_cmp_in,            // Raw comparator outputs, a and b
    input  wire logic       overflow_in,           // Capture timer array overflow pulse
    input  wire logic       xbar_sync_sel_in,      // Crossbar picks synchronised outputs
    input  wire logic       reset_src_en_in,       // Comparator a allowed as reset source
    input  wire logic       pwm_kill_en_in,        // Comparator a allowed to kill PWM
    output logic      [7:0] mux_a_out,             // Comparator a input selects
    output logic      [7:0] mux_b_out,             // Comparator b input selects
    output logic      [1:0] speed_a_out,           // Comparator a speed/power mode
    output logic      [1:0] speed_b_out,           // Comparator b speed/power mode
    output logic      [1:0] xbar_out,              // Outputs routed to crossbar
    output logic      [1:0] irq_out,               // Interrupt requests a and b
    output logic            reset_req_out,         // Reset request from comparator a
    output logic            pwm_kill_out           // PWM kill trigger from comparator a
);
    logic [7:0] mode_ff [2];
    logic [7:0] mux_ff  [2];
    logic [1:0] clr_rise, clr_fall;
    cmpdc_pkg::cmpdc_cfg_s  cfg  [2];
    cmpdc_pkg::cmpdc_stat_s stat [2];
    logic [7:0] nxt_rdata;

    function automatic logic [7:0] mode_view(input logic [7:0] m, input logic lat);
        mode_view = (m & cmpdc_pkg::MODE_WR_MASK) | {lat, 7'h00};
    endfunction

    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] want);
        wr_hit = sfr_wr_in && (a == want);
    endfunction

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode_ff[0] <= cmpdc_pkg::MODE_RESET;
            mode_ff[1] <= cmpdc_pkg::MODE_RESET;
        end else begin
            if (wr_hit(sfr_addr_in, cmpdc_pkg::MODE_ADDR))
                mode_ff[0] <= sfr_wdata_in & cmpdc_pkg::MODE_WR_MASK;
            if (wr_hit(sfr_addr_in, cmpdc_pkg::MODE_B_ADDR))
                mode_ff[1] <= sfr_wdata_in & cmpdc_pkg::MODE_WR_MASK;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mux_ff[0] <= cmpdc_pkg::MUX_RESET;
            mux_ff[1] <= cmpdc_pkg::MUX_RESET;
        end else begin
            if (wr_hit(sfr_addr_in, cmpdc_pkg::MUX_A_ADDR)) mux_ff[0] <= sfr_wdata_in;
            if (wr_hit(sfr_addr_in, cmpdc_pkg::MUX_B_ADDR)) mux_ff[1] <= sfr_wdata_in;
        end
    end

    // Write one to clear; bits 0,1 rising/falling of a, bits 2,3 of b
    always_comb begin
        clr_rise = 2'b00;
        clr_fall = 2'b00;
        if (wr_hit(sfr_addr_in, cmpdc_pkg::FLAG_ADDR)) begin
            clr_rise = {sfr_wdata_in[2], sfr_wdata_in[0]};
            clr_fall = {sfr_wdata_in[3], sfr_wdata_in[1]};
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            assign cfg[g] = '{rise_irq_enable:    mode_ff[g][cmpdc_pkg::RISE_IE_BIT],
                              fall_irq_enable:    mode_ff[g][cmpdc_pkg::FALL_IE_BIT],
                              speed_power_select: mode_ff[g][1:0]};
            cmpdc_channel u_ch (
                .sys_clk_in  (sys_clk_in),
                .nrst_in     (nrst_in),
                .raw_cmp_in  (raw_cmp_in[g]),
                .overflow_in (overflow_in),
                .clr_rise_in (clr_rise[g]),
                .clr_fall_in (clr_fall[g]),
                .cfg_in      (cfg[g]),
                .stat_out    (stat[g])
            );
        end
    endgenerate

    always_comb begin
        nxt_rdata = 8'h00;
        if (sfr_addr_in == cmpdc_pkg::MODE_ADDR)
            nxt_rdata = mode_view(mode_ff[0], stat[0].latched_compare_level);
        else if (sfr_addr_in == cmpdc_pkg::MODE_B_ADDR)
            nxt_rdata = mode_view(mode_ff[1], stat[1].latched_compare_level);
        else if (sfr_addr_in == cmpdc_pkg::MUX_A_ADDR)
            nxt_rdata = mux_ff[0];
        else if (sfr_addr_in == cmpdc_pkg::MUX_B_ADDR)
            nxt_rdata = mux_ff[1];
        else if (sfr_addr_in == cmpdc_pkg::FLAG_ADDR)
            nxt_rdata = {2'h0, stat[1].sync_out, stat[0].sync_out,
                         stat[1].fall_flag, stat[1].rise_flag, stat[0].fall_flag, stat[0].rise_flag};
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in)       sfr_rdata_out <= 8'h00;
        else if (sfr_rd_in) sfr_rdata_out <= nxt_rdata;
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mux_a_out <= cmpdc_pkg::MUX_RESET;
            mux_b_out <= cmpdc_pkg::MUX_RESET;
        end else begin
            mux_a_out <= mux_ff[0];
            mux_b_out <= mux_ff[1];
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            speed_a_out <= cmpdc_pkg::MODE_RESET[1:0];
            speed_b_out <= cmpdc_pkg::MODE_RESET[1:0];
        end else begin
            speed_a_out <= cfg[0].speed_power_select;
            speed_b_out <= cfg[1].speed_power_select;
        end
    end

    // Crossbar takes the synchronised level or the one-flop raw copy
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            xbar_out <= 2'b00;
        end else begin
            xbar_out <= xbar_sync_sel_in ? {stat[1].sync_out, stat[0].sync_out}
                                         : {stat[1].async_out, stat[0].async_out};
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_out <= 2'b00;
        end else begin
            irq_out <= {stat[1].irq, stat[0].irq};
        end
    end

    // Only comparator a may reset the device or kill a PWM channel
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reset_req_out <= 1'b0;
            pwm_kill_out  <= 1'b0;
        end else begin
            reset_req_out <= reset_src_en_in & stat[0].sync_out;
            pwm_kill_out  <= pwm_kill_en_in & stat[0].sync_out;
        end
    end

    rsvd_zero_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        sfr_rd_in && sfr_addr_in == cmpdc_pkg::MODE_ADDR |=> (sfr_rdata_out & 8'h4C) == 8'h00)
        else $error("reserved mode bits read nonzero");
    speed_map_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        sfr_wr_in && sfr_addr_in == cmpdc_pkg::MODE_ADDR |=> ##1 speed_a_out == $past(sfr_wdata_in[1:0], 2))
        else $error("speed select not taken from write");
    kill_path_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        pwm_kill_en_in && stat[0].sync_out |=> pwm_kill_out) else $error("pwm kill missing");
    kill_gate_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        !pwm_kill_en_in |=> !pwm_kill_out) else $error("pwm kill while disabled");
    reset_path_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        reset_src_en_in && stat[0].sync_out |=> reset_req_out) else $error("reset request missing");
    reset_gate_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        !reset_src_en_in |=> !reset_req_out) else $error("reset request while disabled");
    irq_route_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        1'b1 |=> irq_out == $past({stat[1].irq, stat[0].irq})) else $error("irq output not routed");
    xbar_sync_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        xbar_sync_sel_in |=> xbar_out == $past({stat[1].sync_out, stat[0].sync_out}))
        else $error("crossbar sync route wrong");
    xbar_async_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        !xbar_sync_sel_in |=> xbar_out == $past({stat[1].async_out, stat[0].async_out}))
        else $error("crossbar async route wrong");

    // Register file and read path
    speed_b_map_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        sfr_wr_in && sfr_addr_in == cmpdc_pkg::MODE_B_ADDR |=> ##1 speed_b_out == $past(sfr_wdata_in[1:0], 2))
        else $error("speed b select not taken from write");
    mux_a_view_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        sfr_wr_in && sfr_addr_in == cmpdc_pkg::MUX_A_ADDR |=> ##1 mux_a_out == $past(sfr_wdata_in, 2))
        else $error("mux a output not taken from write");
    mux_b_view_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        sfr_wr_in && sfr_addr_in == cmpdc_pkg::MUX_B_ADDR |=> ##1 mux_b_out == $past(sfr_wdata_in, 2))
        else $error("mux b output not taken from write");
    mux_read_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        sfr_rd_in && sfr_addr_in == cmpdc_pkg::MUX_A_ADDR |=> sfr_rdata_out == $past(mux_ff[0]))
        else $error("mux a read wrong");
    latch_read_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        sfr_rd_in && sfr_addr_in == cmpdc_pkg::MODE_ADDR
            |=> sfr_rdata_out[7] == $past(stat[0].latched_compare_level))
        else $error("latched level read wrong");
    latch_b_read_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        sfr_rd_in && sfr_addr_in == cmpdc_pkg::MODE_B_ADDR
            |=> sfr_rdata_out[7] == $past(stat[1].latched_compare_level))
        else $error("latched level b read wrong");
    rsvd_b_zero_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        sfr_rd_in && sfr_addr_in == cmpdc_pkg::MODE_B_ADDR |=> (sfr_rdata_out & 8'h4C) == 8'h00)
        else $error("reserved mode b bits read nonzero");
    flag_read_a: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
        sfr_rd_in && sfr_addr_in == cmpdc_pkg::FLAG_ADDR |=> sfr_rdata_out[3:0] ==
            $past({stat[1].fall_flag, stat[1].rise_flag, stat[0].fall_flag, stat[0].rise_flag}))
        else $error("flag read wrong");
endmodule

// ### tb/cmpdc_analog_model.sv
// Behavioural analog comparator core with source voltages and mode-dependent delay
module cmpdc_analog_model (
    input  wire logic [7:0] mux_a_in,     // Comparator a selects
    input  wire logic [7:0] mux_b_in,     // Comparator b selects
    input  wire logic [1:0] speed_a_in,   // Comparator a mode
    input  wire logic [1:0] speed_b_in,   // Comparator b mode
    input  int              src_mv_in [16], // Source voltages in mV
    output logic      [1:0] raw_cmp_out   // Raw outputs
);
    timeunit 1ns;
    timeprecision 1ns;
    initial raw_cmp_out = 2'h0;
    // Plus source in upper nibble, minus in lower; slower modes answer later, never on a clock edge
    always #5 begin
        raw_cmp_out[0] <= #(10 * (speed_a_in + 1) + 2)
                          (src_mv_in[mux_a_in[7:4]] > src_mv_in[mux_a_in[3:0]]);
        raw_cmp_out[1] <= #(10 * (speed_b_in + 1) + 2)
                          (src_mv_in[mux_b_in[7:4]] > src_mv_in[mux_b_in[3:0]]);
    end
endmodule

// ### tb/tb_top.sv
// Self-checking testbench for the comparator digital control block
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, ov = 1'b0, ssel = 1'b1, rsen = 1'b0, pken = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, mux_a, mux_b;
    logic [1:0] raw, spa, spb, xbar, irq;
    logic       rreq, pkill;
    int         src_mv [16];
    int         fail_count = 0, comparisons = 0;
    initial forever #25 clk = ~clk;
    cmpdc_top u_dut (.sys_clk_in(clk), .nrst_in(nrst), .sfr_addr_in(addr), .sfr_wdata_in(wdata),
        .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rdata_out(rdata), .raw_cmp_in(raw), .overflow_in(ov),
        .xbar_sync_sel_in(ssel), .reset_src_en_in(rsen), .pwm_kill_en_in(pken), .mux_a_out(mux_a),
        .mux_b_out(mux_b), .speed_a_out(spa), .speed_b_out(spb), .xbar_out(xbar), .irq_out(irq),
        .reset_req_out(rreq), .pwm_kill_out(pkill));
    cmpdc_analog_model u_model (.mux_a_in(mux_a), .mux_b_in(mux_b), .speed_a_in(spa), .speed_b_in(spb),
        .src_mv_in(src_mv), .raw_cmp_out(raw));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
        @(posedge clk) wr <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) begin addr <= a; rd <= 1'b1; end
        @(posedge clk) rd <= 1'b0;
        @(negedge clk) chk(rdata, exp);
    endtask
    task automatic set_level(input int ch, input bit hi);
        @(posedge clk) src_mv[ch ? 3 : 1] <= hi ? 1500 : 500;
        repeat (10) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic ov_pulse();
        @(posedge clk) ov <= 1'b1;
        @(posedge clk) ov <= 1'b0;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        summarize();
    end
    initial begin
        logic [7:0] ma;
        logic [7:0] rb;
        // Only analog levels reach the selected sources; pins are treated as skipped analog inputs
        foreach (src_mv[i]) src_mv[i] = 0;
        src_mv[0] = 1000;
        src_mv[2] = 1000;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        rd_chk(cmpdc_pkg::MODE_ADDR, 8'h02);
        chk({6'h00, spa}, 8'h02);
        rd_chk(8'h55, 8'h00);
        wr_reg(cmpdc_pkg::MODE_ADDR, 8'hB3);
        rd_chk(cmpdc_pkg::MODE_ADDR, 8'h33);
        for (int m = 0; m < 4; m++) begin
            wr_reg(cmpdc_pkg::MODE_ADDR, 8'(m));
            chk({6'h00, spa}, 8'(m));
        end
        wr_reg(cmpdc_pkg::MUX_A_ADDR, 8'h10);
        wr_reg(cmpdc_pkg::MUX_B_ADDR, 8'h32);
        rd_chk(cmpdc_pkg::MUX_A_ADDR, 8'h10);
        chk(mux_b, 8'h32);
        $display("test registers done");
        for (int ch = 0; ch < 2; ch++) begin
            ma = ch ? cmpdc_pkg::MODE_B_ADDR : cmpdc_pkg::MODE_ADDR;
            rb = 8'h01 << (2 * ch);
            wr_reg(ma, 8'h22);
            chk({6'h00, ch ? spb : spa}, 8'h02);
            set_level(ch, 1'b1);
            chk({7'h00, irq[ch]}, 8'h01);
            rd_chk(cmpdc_pkg::FLAG_ADDR, rb | (8'h10 << ch));
            wr_reg(cmpdc_pkg::FLAG_ADDR, rb);
            chk({7'h00, irq[ch]}, 8'h00);
            set_level(ch, 1'b0);
            chk({7'h00, irq[ch]}, 8'h00);
            rd_chk(cmpdc_pkg::FLAG_ADDR, rb << 1);
            wr_reg(cmpdc_pkg::FLAG_ADDR, rb << 1);
            wr_reg(ma, 8'h12);
            set_level(ch, 1'b1);
            chk({7'h00, irq[ch]}, 8'h00);
            rd_chk(cmpdc_pkg::FLAG_ADDR, rb | (8'h10 << ch));
            wr_reg(cmpdc_pkg::FLAG_ADDR, rb);
            set_level(ch, 1'b0);
            chk({7'h00, irq[ch]}, 8'h01);
            wr_reg(cmpdc_pkg::FLAG_ADDR, rb << 1);
            wr_reg(ma, 8'h02);
        end
        $display("test edges done");
        set_level(0, 1'b1);
        ov_pulse();
        rd_chk(cmpdc_pkg::MODE_ADDR, 8'h82);
        set_level(0, 1'b0);
        rd_chk(cmpdc_pkg::MODE_ADDR, 8'h82);
        ov_pulse();
        rd_chk(cmpdc_pkg::MODE_ADDR, 8'h02);
        $display("test latch done");
        @(posedge clk) rsen <= 1'b1;
        set_level(0, 1'b1);
        chk({6'h00, xbar}, 8'h01);
        chk({6'h00, rreq, pkill}, 8'h02);
        @(posedge clk) begin ssel <= 1'b0; rsen <= 1'b0; pken <= 1'b1; end
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk({6'h00, xbar}, 8'h01);
        chk({6'h00, rreq, pkill}, 8'h01);
        @(posedge clk) src_mv[1] <= 500;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({5'h00, xbar, pkill}, 8'h01);
        $display("test routing done");
        summarize();
    end
endmodule
